// >>> dv/pwc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_pulse_src (
  input wire logic ref_clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // a real source moves just after an edge; the channel synchronises it
  task automatic idle(input logic lvl);
    @(posedge ref_clk_i);
    pin_o <= lvl;
  endtask
  // one pulse of level act, w cycles long, then back
  task automatic pulse(input logic act, input int w);
    @(posedge ref_clk_i);
    pin_o <= act;
    repeat (w) @(posedge ref_clk_i);
    pin_o <= ~act;
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import pwc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gate = 1'b0;
  logic [PSC_W-1:0] sel_a = 4'h0;
  logic [PSC_W-1:0] sel_b = 4'h0;
  logic ocs = 1'b0;
  logic [EDGE_SEL_W-1:0] es = 2'h3;
  logic st_wr = 1'b0;
  logic sp_wr = 1'b0;
  logic d_wr = 1'b0;
  logic [CNT_W-1:0] wd = 16'h0000;
  logic pin;
  logic act, stb, spb, ovf, irq;
  logic [CNT_W-1:0] cnt, dat, held;
  int n_fail = 0;
  int num_checks = 0;
  int h;
  always #25 clk = ~clk;
  pwc_channel i_pwc_channel (.ref_clk_i(clk), .resetn_i(rst_n), .unit_gate_i(gate),
    .prescaler_sel_a_i(sel_a), .prescaler_sel_b_i(sel_b), .operating_clock_select_i(ocs),
    .edge_select_i(es), .start_trigger_wr_i(st_wr), .stop_trigger_wr_i(sp_wr),
    .data_wr_i(d_wr), .data_wdata_i(wd), .capture_input_pin_i(pin),
    .channel_active_flag_o(act), .start_trigger_bit_o(stb), .stop_trigger_bit_o(spb),
    .channel_counter_o(cnt), .channel_data_register_o(dat), .overflow_flag_o(ovf),
    .channel_interrupt_o(irq));
  pwc_pulse_src i_pwc_pulse_src (.ref_clk_i(clk), .pin_o(pin));
  function automatic logic [CNT_W:0] exp_cap(input int w);
    exp_cap = {w > 65536, 16'(w - 1)};
  endfunction
  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // raw start write, no expectation of its own
  task automatic wr_start();
    @(posedge clk);
    st_wr <= 1'b1;
    @(posedge clk);
    st_wr <= 1'b0;
  endtask
  // start write two edges into a pulse, while the channel is measuring
  task automatic wr_start_late();
    cyc(2);
    wr_start();
  endtask
  task automatic trig(input logic is_start);
    int k;
    k = 0;
    @(posedge clk);
    if (is_start) st_wr <= 1'b1;
    else sp_wr <= 1'b1;
    @(posedge clk);
    st_wr <= 1'b0;
    sp_wr <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      if ((is_start ? stb : spb) === 1'b1) k++;
    end
    `CHK(k, 1)
    `CHK(act, is_start)
  endtask
  task automatic measure(input logic lvl, input int w, input bit exact);
    int k;
    k = 0;
    i_pwc_pulse_src.pulse(lvl, w);
    while (irq !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    `CHK(k < 100, 1'b1)
    if (exact) `CHK({ovf, dat}, exp_cap(w))
    else `CHK((int'(dat) + 1) * 4 >= w - 8 && (int'(dat) + 1) * 4 <= w + 8, 1'b1)
    `CHK(cnt, dat + 16'h0001)
    @(negedge clk);
    `CHK(irq, 1'b0)
  endtask
  initial begin
    void'($urandom(89340));
    cyc(6);
    rst_n <= 1'b1;
    gate <= 1'b1;
    @(negedge clk);
    `CHK({act, stb, spb, cnt, dat, ovf, irq}, 37'h0)
    @(posedge clk);
    es <= EDGE_SEL_HIGH;
    trig(1'b1);
    // active flag stays set while running, even across a start write
    for (int i = 0; i < 6; i++) begin
      h = 2 + $urandom_range(300);
      if (i == 3) begin
        fork
          wr_start_late();
        join_none
      end
      measure(1'b1, h, 1'b1);
      `CHK(act, 1'b1)
    end
    trig(1'b0);
    i_pwc_pulse_src.idle(1'b1);
    es <= EDGE_SEL_LOW;
    trig(1'b1);
    for (int i = 0; i < 3; i++) begin
      h = 2 + $urandom_range(300);
      measure(1'b0, h, 1'b1);
    end
    trig(1'b0);
    i_pwc_pulse_src.idle(1'b0);
    es <= EDGE_SEL_HIGH;
    sel_b <= 4'h2;
    ocs <= CKS_CLOCK_B;
    trig(1'b1);
    for (int i = 0; i < 3; i++) begin
      h = 40 + $urandom_range(360);
      measure(1'b1, h, 1'b0);
    end
    trig(1'b0);
    @(posedge clk);
    ocs <= CKS_CLOCK_A;
    trig(1'b1);
    // single wrap: flag set, low bits still meaningful
    measure(1'b1, 65540, 1'b1);
    i_pwc_pulse_src.idle(1'b1);
    cyc(30);
    trig(1'b0);
    held = cnt;
    cyc(10);
    @(negedge clk);
    `CHK(cnt, held)
    `CHK(ovf, 1'b1)
    i_pwc_pulse_src.idle(1'b0);
    trig(1'b1);
    measure(1'b1, 50, 1'b1);
    trig(1'b0);
    // an edge select code outside 10 and 11 must never start a measurement
    @(posedge clk);
    es <= 2'h1;
    trig(1'b1);
    i_pwc_pulse_src.pulse(1'b1, 20);
    cyc(8);
    @(negedge clk);
    `CHK({cnt, dat}, {16'h0032, 16'h0031})
    trig(1'b0);
    @(posedge clk);
    wd <= 16'($urandom);
    d_wr <= 1'b1;
    @(posedge clk);
    d_wr <= 1'b0;
    cyc(2);
    @(negedge clk);
    `CHK(dat, wd)
    @(posedge clk);
    gate <= 1'b0;
    wr_start();
    cyc(4);
    @(negedge clk);
    `CHK({act, stb, spb, cnt, dat, ovf, irq}, 37'h0)
    results();
  end
  initial begin
    cyc(100000);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire

// >>> rtl/pwc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_channel import pwc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic unit_gate_i,
  input wire logic [PSC_W-1:0] prescaler_sel_a_i,
  input wire logic [PSC_W-1:0] prescaler_sel_b_i,
  input wire logic operating_clock_select_i,
  input wire logic [EDGE_SEL_W-1:0] edge_select_i,
  input wire logic start_trigger_wr_i,
  input wire logic stop_trigger_wr_i,
  input wire logic data_wr_i,
  input wire logic [CNT_W-1:0] data_wdata_i,
  input wire logic capture_input_pin_i,
  output logic channel_active_flag_o,
  output logic start_trigger_bit_o,
  output logic stop_trigger_bit_o,
  output logic [CNT_W-1:0] channel_counter_o,
  output logic [CNT_W-1:0] channel_data_register_o,
  output logic overflow_flag_o,
  output logic channel_interrupt_o
);

  // gate low acts like a reset on every register of the channel
  logic clear_w;
  assign clear_w = !resetn_i || !unit_gate_i;

  // shared prescaled clocks, delivered as one-cycle ticks
  logic tick_a_w;
  logic tick_b_w;
  logic op_tick_w;

  pwc_prescaler u_prescaler (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .unit_gate_i(unit_gate_i),
    .sel_a_i(prescaler_sel_a_i),
    .sel_b_i(prescaler_sel_b_i),
    .tick_a_o(tick_a_w),
    .tick_b_o(tick_b_w)
  );

  // operating clock doubles as count clock in this mode
  assign op_tick_w = (operating_clock_select_i == CKS_CLOCK_B) ? tick_b_w : tick_a_w;

  // pin synchroniser and sampler
  logic pin_s1_r;
  logic pin_s1_nxt;
  logic pin_s2_r;
  logic pin_s2_nxt;
  logic pin_smp_r;
  logic pin_smp_nxt;

  always_comb begin
    pin_s1_nxt = capture_input_pin_i;
    pin_s2_nxt = pin_s1_r;
    pin_smp_nxt = pin_smp_r;
    // only the operating clock looks at the pin, hence up to one period of error
    if (op_tick_w) begin
      pin_smp_nxt = pin_s2_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clear_w) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_smp_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      pin_smp_r <= pin_smp_nxt;
    end
  end

  logic rise_w;
  logic fall_w;
  logic start_edge_w;
  logic capture_edge_w;
  logic sel_valid_w;

  assign rise_w = op_tick_w && pin_s2_r && !pin_smp_r;
  assign fall_w = op_tick_w && !pin_s2_r && pin_smp_r;
  // codes other than 10 and 11 select no width measurement: no edges at all
  assign sel_valid_w = (edge_select_i == EDGE_SEL_HIGH) || (edge_select_i == EDGE_SEL_LOW);
  assign start_edge_w = sel_valid_w &&
    ((edge_select_i == EDGE_SEL_HIGH) ? rise_w : fall_w);
  assign capture_edge_w = sel_valid_w &&
    ((edge_select_i == EDGE_SEL_HIGH) ? fall_w : rise_w);

  // self-clearing trigger bits
  logic start_trig_r;
  logic start_trig_nxt;
  logic stop_trig_r;
  logic stop_trig_nxt;

  always_comb begin
    // a bit holds one only in the cycle after its write
    start_trig_nxt = start_trigger_wr_i;
    stop_trig_nxt = stop_trigger_wr_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (clear_w) begin
      start_trig_r <= 1'b0;
      stop_trig_r <= 1'b0;
    end else begin
      start_trig_r <= start_trig_nxt;
      stop_trig_r <= stop_trig_nxt;
    end
  end

  // channel measurement state
  pwc_state_t state_r;
  pwc_state_t state_nxt;
  logic active_r;
  logic active_nxt;
  logic [CNT_W-1:0] counter_r;
  logic [CNT_W-1:0] counter_nxt;
  logic [CNT_W-1:0] data_r;
  logic [CNT_W-1:0] data_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic wrap_seen_r;
  logic wrap_seen_nxt;
  logic irq_r;
  logic irq_nxt;

  always_comb begin
    state_nxt = state_r;
    active_nxt = active_r;
    counter_nxt = counter_r;
    data_nxt = data_r;
    ovf_nxt = ovf_r;
    wrap_seen_nxt = wrap_seen_r;
    irq_nxt = 1'b0;
    // software data write; a capture in the same cycle overrides it
    if (data_wr_i) begin
      data_nxt = data_wdata_i;
    end
    if (stop_trig_r) begin
      // stop wins over a simultaneous start or edge
      active_nxt = 1'b0;
      state_nxt = PWC_STOPPED;
    end else if (start_trig_r && !active_r) begin
      active_nxt = 1'b1;
      state_nxt = PWC_WAIT_START;
    end else begin
      // a start write while active falls through here untouched
      unique case (state_r)
        PWC_STOPPED: begin
          state_nxt = PWC_STOPPED;
        end
        PWC_WAIT_START: begin
          if (start_edge_w) begin
            counter_nxt = COUNTER_RST;
            wrap_seen_nxt = 1'b0;
            state_nxt = PWC_MEASURE;
          end
        end
        PWC_MEASURE: begin
          // up count on every count clock, wrapping at all ones
          if (op_tick_w) begin
            counter_nxt = counter_r + CNT_ONE;
          end
          if (capture_edge_w) begin
            data_nxt = counter_r;
            irq_nxt = 1'b1;
            // counter is left at captured value plus one
            ovf_nxt = wrap_seen_r;
            state_nxt = PWC_WAIT_START;
          end else if (op_tick_w && counter_r == CNT_MAX) begin
            // single sticky bit: extra wraps are indistinguishable
            wrap_seen_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clear_w) begin
      // channel starts stopped whenever the gate is raised
      state_r <= PWC_STOPPED;
      active_r <= 1'b0;
      counter_r <= COUNTER_RST;
      data_r <= DATA_RST;
      ovf_r <= OVF_RST;
      wrap_seen_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      active_r <= active_nxt;
      counter_r <= counter_nxt;
      data_r <= data_nxt;
      ovf_r <= ovf_nxt;
      wrap_seen_r <= wrap_seen_nxt;
      irq_r <= irq_nxt;
    end
  end

  // width = period * (ovf * OVF_WEIGHT + data + 1), read back by software
  assign channel_active_flag_o = active_r;
  assign start_trigger_bit_o = start_trig_r;
  assign stop_trigger_bit_o = stop_trig_r;
  assign channel_counter_o = counter_r;
  assign channel_data_register_o = data_r;
  assign overflow_flag_o = ovf_r;
  assign channel_interrupt_o = irq_r;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (clear_w);

  property p_trig_self_clear;
    !start_trigger_wr_i && !stop_trigger_wr_i |=> !start_trig_r && !stop_trig_r;
  endproperty
  a_trig_self_clear: assert property (p_trig_self_clear)
    else $error("trigger bit did not clear itself");

  property p_start_arms;
    start_trig_r && !active_r && !stop_trig_r
      |=> active_r && state_r == PWC_WAIT_START;
  endproperty
  a_start_arms: assert property (p_start_arms)
    else $error("start trigger did not arm the channel");

  property p_start_ignored;
    start_trig_r && active_r && !stop_trig_r && state_r == PWC_MEASURE
      && !capture_edge_w |=> state_r == PWC_MEASURE;
  endproperty
  a_start_ignored: assert property (p_start_ignored)
    else $error("start trigger restarted an active channel");

  property p_stop_holds;
    stop_trig_r |=> !active_r && state_r == PWC_STOPPED
      && $stable(counter_r) && $stable(ovf_r);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("stop did not halt and hold");

  property p_start_clears;
    state_r == PWC_WAIT_START && start_edge_w && !stop_trig_r
      && !start_trig_r |=> counter_r == COUNTER_RST && state_r == PWC_MEASURE;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("start edge did not clear the counter");

  property p_counts_up;
    state_r == PWC_MEASURE && op_tick_w && !stop_trig_r
      |=> counter_r == $past(counter_r) + CNT_ONE;
  endproperty
  a_counts_up: assert property (p_counts_up)
    else $error("counter did not count up");

  property p_capture_copy;
    state_r == PWC_MEASURE && capture_edge_w && !stop_trig_r
      |=> irq_r && data_r == $past(counter_r);
  endproperty
  a_capture_copy: assert property (p_capture_copy)
    else $error("capture did not copy counter with interrupt");

  property p_after_capture;
    irq_r |-> counter_r == data_r + CNT_ONE && state_r == PWC_WAIT_START
      ##1 !irq_r;
  endproperty
  a_after_capture: assert property (p_after_capture)
    else $error("counter not at captured value plus one");

  property p_ovf_clear;
    irq_r && !$past(wrap_seen_r) |-> !ovf_r;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag set without a wrap");

  property p_ovf_set;
    irq_r && $past(wrap_seen_r) |-> ovf_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set after a wrap");

endmodule
`default_nettype wire

// >>> rtl/pwc_pkg.sv
package pwc_pkg;

  // counter and data register geometry
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] COUNTER_RST = 16'h0000;
  localparam logic [CNT_W-1:0] DATA_RST = 16'h0000;
  localparam logic OVF_RST = 1'b0;

  // weight of the overflow flag in the width formula
  localparam logic [CNT_W:0] OVF_WEIGHT = 17'h10000;

  // edge select field encodings
  localparam int EDGE_SEL_W = 2;
  localparam logic [EDGE_SEL_W-1:0] EDGE_SEL_LOW = 2'b10;
  localparam logic [EDGE_SEL_W-1:0] EDGE_SEL_HIGH = 2'b11;

  // prescaler: shared divider, each selection picks 2^sel
  localparam int PSC_W = 4;
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

  // operating clock select values
  localparam logic CKS_CLOCK_A = 1'b0;
  localparam logic CKS_CLOCK_B = 1'b1;

  typedef enum logic [1:0] {
    PWC_STOPPED,
    PWC_WAIT_START,
    PWC_MEASURE
  } pwc_state_t;

endpackage

// >>> rtl/pwc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_prescaler import pwc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic unit_gate_i,
  input wire logic [PSC_W-1:0] sel_a_i,
  input wire logic [PSC_W-1:0] sel_b_i,
  output logic tick_a_o,
  output logic tick_b_o
);

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [DIV_W-1:0] mask_a;
  logic [DIV_W-1:0] mask_b;
  logic tick_a_r;
  logic tick_a_nxt;
  logic tick_b_r;
  logic tick_b_nxt;

  // mask holds the low sel bits; a tick fires when they are all ones
  genvar gi;
  generate
    for (gi = 0; gi < DIV_W; gi++) begin : g_mask
      assign mask_a[gi] = (gi < int'(sel_a_i));
      assign mask_b[gi] = (gi < int'(sel_b_i));
    end
  endgenerate

  always_comb begin
    div_nxt = div_r + DIV_ONE;
    tick_a_nxt = &(div_r | ~mask_a);
    tick_b_nxt = &(div_r | ~mask_b);
  end

  // gate low holds the whole prescaler in its initial state
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !unit_gate_i) begin
      div_r <= DIV_RST;
      tick_a_r <= 1'b0;
      tick_b_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_a_r <= tick_a_nxt;
      tick_b_r <= tick_b_nxt;
    end
  end

  assign tick_a_o = tick_a_r;
  assign tick_b_o = tick_b_r;

endmodule
`default_nettype wire
